/* hw/charger_regs_map.svh */
// constants for the charger status, fault and input floor registers
// assumes byte-wide registers reached through a byte register port
`ifndef CHARGER_REGS_MAP_SVH
`define CHARGER_REGS_MAP_SVH

// register offsets
`define ADDR_INPUT_CHARGE_STATUS 8'h0b
`define ADDR_FAULT_STATUS        8'h0c
`define ADDR_INPUT_FLOOR_CTRL    8'h0d

// input and charge status fields
`define SRC_TYPE_MSB             7
`define SRC_TYPE_LSB             5
`define PHASE_MSB                4
`define PHASE_LSB                3
`define POWER_GOOD_BIT           2
`define STATUS_UNUSED_BIT        1
`define SYS_MIN_BIT              0

// fault status fields
`define WDOG_FAULT_BIT           7
`define BOOST_FAULT_BIT          6
`define CHG_FAULT_MSB            5
`define CHG_FAULT_LSB            4
`define BATTERY_OVERVOLT_FAULT_BIT            3
`define THERM_FAULT_MSB          2
`define THERM_FAULT_LSB          0

// input floor control fields and values
`define ABS_SELECT_BIT           7
`define FLOOR_MSB                6
`define FLOOR_LSB                0
`define ABS_SELECT_RESET         1'b0
`define FLOOR_RESET_CODE         7'h12
`define FLOOR_RESET_MV           14'h1130
`define FLOOR_MIN_CODE           7'h0d
`define FLOOR_OFFSET_MV          14'h0a28
`define FLOOR_STEP_MV            14'h0064

// number of pin inputs passed through the synchroniser
`define PIN_SYNC_WIDTH           19

`endif

/* hw/charger_regs_pkg.sv */
// types shared by the charger register logic
// assumes charger_regs_map.svh is on the include path
`include "charger_regs_map.svh"

package charger_regs_pkg;

  typedef enum logic [2:0] {
    SRC_NONE       = 3'h0,
    SRC_HOST_STD   = 3'h1,
    SRC_HOST_CHG   = 3'h2,
    SRC_DEDICATED  = 3'h3,
    SRC_HIGH_VOLT  = 3'h4,
    SRC_UNKNOWN    = 3'h5,
    SRC_NONSTD     = 3'h6,
    SRC_BOOST_OUT  = 3'h7
  } source_type_type;

  typedef enum logic [1:0] {
    PHASE_IDLE     = 2'h0,
    PHASE_PRE      = 2'h1,
    PHASE_FAST     = 2'h2,
    PHASE_DONE     = 2'h3
  } charge_phase_type;

  typedef enum logic [1:0] {
    CHG_FLT_NONE   = 2'h0,
    CHG_FLT_INPUT  = 2'h1,
    CHG_FLT_THERM  = 2'h2,
    CHG_FLT_TIMER  = 2'h3
  } charge_fault_type;

  typedef enum logic [2:0] {
    TS_NORMAL      = 3'h0,
    TS_COLD        = 3'h1,
    TS_HOT         = 3'h2
  } thermistor_type;

  typedef struct packed {
    logic [7:0]  rdata;
    logic        abs_sel;
    logic [6:0]  floor;
    logic [13:0] floor_mv;
    logic        wdog_flt;
    logic        vbus_prev;
  } reg_state_type;

  // codes below the floor minimum are raised to it
  function automatic logic [6:0] clamp_floor(input logic [6:0] code);
    clamp_floor = (code < `FLOOR_MIN_CODE) ? `FLOOR_MIN_CODE : code;
  endfunction : clamp_floor

endpackage : charger_regs_pkg

/* hw/charger_status_fault_vin_floor_regs.sv */
// status, fault and input voltage floor registers of the charger
// assumes a serial bus engine on CLK presents single-cycle byte
// reads and writes; analog status arrives on asynchronous pins
`timescale 1ns/1ps

`include "charger_regs_map.svh"

module charger_status_fault_vin_floor_regs
  import charger_regs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [2:0]  SOURCE_TYPE_PIN,
  input  wire logic [1:0]  CHARGE_PHASE_PIN,
  input  wire logic        POWER_GOOD_PIN,
  input  wire logic        SYS_MIN_REG_PIN,
  input  wire logic        BOOST_MODE_PIN,
  input  wire logic        BOOST_OVERLOAD_PIN,
  input  wire logic        BOOST_OVERVOLT_PIN,
  input  wire logic        BOOST_BAT_LOW_PIN,
  input  wire logic        INPUT_OVERVOLT_PIN,
  input  wire logic        INPUT_UNDERVOLT_PIN,
  input  wire logic        THERMAL_SHUTDOWN_PIN,
  input  wire logic        SAFETY_TIMER_PIN,
  input  wire logic        BAT_OVERVOLT_PIN,
  input  wire logic        TS_COLD_PIN,
  input  wire logic        TS_HOT_PIN,
  input  wire logic        VBUS_PRESENT_PIN,
  input  wire logic        WDOG_EXPIRE,
  input  wire logic [6:0]  RELATIVE_FLOOR,
  output logic             ABS_FLOOR_SELECT,
  output logic      [6:0]  INPUT_FLOOR_CODE,
  output logic      [13:0] INPUT_FLOOR_MV
);

  logic [`PIN_SYNC_WIDTH-1:0] pins_raw;
  logic [`PIN_SYNC_WIDTH-1:0] pins_sync;

  source_type_type  src_s;
  charge_phase_type phase_s;
  logic             pg_s;
  logic             sysmin_s;
  logic             boost_mode_s;
  logic             boost_ovl_s;
  logic             boost_ovp_s;
  logic             boost_low_s;
  logic             in_ovp_s;
  logic             in_uv_s;
  logic             therm_s;
  logic             timer_s;
  logic             bat_ovp_s;
  logic             ts_cold_s;
  logic             ts_hot_s;
  logic             vbus_s;

  reg_state_type    st_ff;
  reg_state_type    nxt_st;

  logic             plug_in;
  logic             wr_floor;
  logic             rd_fault;
  charge_fault_type chg_fault;
  thermistor_type   therm_code;
  logic             boost_fault;
  logic [7:0]       status_byte;
  logic [7:0]       fault_byte;
  logic [7:0]       floor_byte;

  // every analog flag is a pin level; multi-bit codes may show one
  // mixed sample while they change, which the host reads past
  assign pins_raw = {SOURCE_TYPE_PIN, CHARGE_PHASE_PIN, POWER_GOOD_PIN,
                     SYS_MIN_REG_PIN, BOOST_MODE_PIN, BOOST_OVERLOAD_PIN,
                     BOOST_OVERVOLT_PIN, BOOST_BAT_LOW_PIN,
                     INPUT_OVERVOLT_PIN, INPUT_UNDERVOLT_PIN,
                     THERMAL_SHUTDOWN_PIN, SAFETY_TIMER_PIN,
                     BAT_OVERVOLT_PIN, TS_COLD_PIN, TS_HOT_PIN,
                     VBUS_PRESENT_PIN};

  pin_sync #(
    .WIDTH    (`PIN_SYNC_WIDTH)
  ) u_pin_sync (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .clk_en   (CLK_EN),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign src_s        = source_type_type'(pins_sync[18:16]);
  assign phase_s      = charge_phase_type'(pins_sync[15:14]);
  assign pg_s         = pins_sync[13];
  assign sysmin_s     = pins_sync[12];
  assign boost_mode_s = pins_sync[11];
  assign boost_ovl_s  = pins_sync[10];
  assign boost_ovp_s  = pins_sync[9];
  assign boost_low_s  = pins_sync[8];
  assign in_ovp_s     = pins_sync[7];
  assign in_uv_s      = pins_sync[6];
  assign therm_s      = pins_sync[5];
  assign timer_s      = pins_sync[4];
  assign bat_ovp_s    = pins_sync[3];
  assign ts_cold_s    = pins_sync[2];
  assign ts_hot_s     = pins_sync[1];
  assign vbus_s       = pins_sync[0];

  assign plug_in  = vbus_s && !st_ff.vbus_prev;
  assign wr_floor = REG_WR && (REG_ADDR == `ADDR_INPUT_FLOOR_CTRL);
  assign rd_fault = REG_RD && (REG_ADDR == `ADDR_FAULT_STATUS);

  // boost faults only count while the boost converter runs
  assign boost_fault = boost_mode_s &&
                       (boost_ovl_s || boost_ovp_s || boost_low_s);

  // input fault outranks thermal shutdown, which outranks the timer
  always_comb begin
    if (in_ovp_s || in_uv_s) begin
      chg_fault = CHG_FLT_INPUT;
    end else if (therm_s) begin
      chg_fault = CHG_FLT_THERM;
    end else if (timer_s) begin
      chg_fault = CHG_FLT_TIMER;
    end else begin
      chg_fault = CHG_FLT_NONE;
    end
  end

  // thermistor code is defined for buck mode only
  always_comb begin
    if (boost_mode_s) begin
      therm_code = TS_NORMAL;
    end else if (ts_cold_s) begin
      therm_code = TS_COLD;
    end else if (ts_hot_s) begin
      therm_code = TS_HOT;
    end else begin
      therm_code = TS_NORMAL;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`SRC_TYPE_MSB:`SRC_TYPE_LSB] = src_s;
    status_byte[`PHASE_MSB:`PHASE_LSB]       = phase_s;
    status_byte[`POWER_GOOD_BIT]             = pg_s;
    status_byte[`STATUS_UNUSED_BIT]          = 1'b0;
    status_byte[`SYS_MIN_BIT]                = sysmin_s;
  end

  always_comb begin
    fault_byte = 8'h00;
    fault_byte[`WDOG_FAULT_BIT]                  = st_ff.wdog_flt;
    fault_byte[`BOOST_FAULT_BIT]                 = boost_fault;
    fault_byte[`CHG_FAULT_MSB:`CHG_FAULT_LSB]    = chg_fault;
    fault_byte[`BATTERY_OVERVOLT_FAULT_BIT]                   = bat_ovp_s;
    fault_byte[`THERM_FAULT_MSB:`THERM_FAULT_LSB] = therm_code;
  end

  assign floor_byte = {st_ff.abs_sel, st_ff.floor};

  always_comb begin
    nxt_st = st_ff;
    if (CLK_EN) begin
      nxt_st.vbus_prev = vbus_s;

      // read data; unmapped offsets answer zero
      if (REG_RD) begin
        case (REG_ADDR)
          `ADDR_INPUT_CHARGE_STATUS: nxt_st.rdata = status_byte;
          `ADDR_FAULT_STATUS:        nxt_st.rdata = fault_byte;
          `ADDR_INPUT_FLOOR_CTRL:    nxt_st.rdata = floor_byte;
          default:                   nxt_st.rdata = 8'h00;
        endcase
      end

      // watchdog flag is sticky until read; a new expiry wins
      if (rd_fault) begin
        nxt_st.wdog_flt = 1'b0;
      end
      if (WDOG_EXPIRE) begin
        nxt_st.wdog_flt = 1'b1;
      end

      // relative mode lets internal control own the floor field
      if (!st_ff.abs_sel) begin
        nxt_st.floor = clamp_floor(RELATIVE_FLOOR);
      end

      // writes to the status and fault offsets fall through here
      if (wr_floor) begin
        nxt_st.abs_sel = REG_WDATA[`ABS_SELECT_BIT];
        if (st_ff.abs_sel) begin
          nxt_st.floor =
            clamp_floor(REG_WDATA[`FLOOR_MSB:`FLOOR_LSB]);
        end
      end

      // plug-in beats any write in the same cycle
      if (plug_in) begin
        nxt_st.abs_sel = `ABS_SELECT_RESET;
        nxt_st.floor   = `FLOOR_RESET_CODE;
      end

      nxt_st.floor_mv = `FLOOR_OFFSET_MV +
                        14'(nxt_st.floor) * `FLOOR_STEP_MV;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '{rdata:     8'h00,
                 abs_sel:   `ABS_SELECT_RESET,
                 floor:     `FLOOR_RESET_CODE,
                 floor_mv:  `FLOOR_RESET_MV,
                 wdog_flt:  1'b0,
                 vbus_prev: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA        = st_ff.rdata;
  assign ABS_FLOOR_SELECT = st_ff.abs_sel;
  assign INPUT_FLOOR_CODE = st_ff.floor;
  assign INPUT_FLOOR_MV   = st_ff.floor_mv;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_floor_min_clamp: assert property (
    INPUT_FLOOR_CODE >= `FLOOR_MIN_CODE
  ) else $error("floor code below clamp minimum");

  a_floor_mv_scale: assert property (
    INPUT_FLOOR_MV == `FLOOR_OFFSET_MV +
                      14'(INPUT_FLOOR_CODE) * `FLOOR_STEP_MV
  ) else $error("floor millivolts disagree with floor code");

  a_plug_restore: assert property (
    CLK_EN && plug_in |=> !ABS_FLOOR_SELECT &&
                          INPUT_FLOOR_CODE == `FLOOR_RESET_CODE
  ) else $error("plug-in did not restore floor defaults");

  a_relative_lock: assert property (
    CLK_EN && !ABS_FLOOR_SELECT && !plug_in |=>
      INPUT_FLOOR_CODE == clamp_floor($past(RELATIVE_FLOOR))
  ) else $error("floor not following relative control");

  a_absolute_write: assert property (
    CLK_EN && wr_floor && ABS_FLOOR_SELECT && !plug_in |=>
      INPUT_FLOOR_CODE == clamp_floor($past(REG_WDATA[6:0])) &&
      ABS_FLOOR_SELECT == $past(REG_WDATA[7])
  ) else $error("absolute floor write not applied");

  a_absolute_hold: assert property (
    CLK_EN && ABS_FLOOR_SELECT && !wr_floor && !plug_in |=>
      $stable(INPUT_FLOOR_CODE) && ABS_FLOOR_SELECT
  ) else $error("absolute floor changed without a write");

  a_status_read: assert property (
    CLK_EN && REG_RD && REG_ADDR == `ADDR_INPUT_CHARGE_STATUS |=>
      REG_RDATA == {$past(src_s), $past(phase_s), $past(pg_s),
                    1'b0, $past(sysmin_s)}
  ) else $error("status read does not match inputs");

  a_wdog_sticky: assert property (
    CLK_EN && WDOG_EXPIRE ##1 CLK_EN && rd_fault |=>
      REG_RDATA[`WDOG_FAULT_BIT]
  ) else $error("watchdog fault lost before read");

  a_wdog_clear: assert property (
    CLK_EN && rd_fault && !WDOG_EXPIRE ##1 CLK_EN && rd_fault
      && !WDOG_EXPIRE |=> !REG_RDATA[`WDOG_FAULT_BIT]
  ) else $error("watchdog fault not cleared by read");

  a_fault_read: assert property (
    CLK_EN && rd_fault |=>
      REG_RDATA[6] == $past(boost_fault) &&
      REG_RDATA[5:4] == $past(chg_fault) &&
      REG_RDATA[3] == $past(bat_ovp_s)
  ) else $error("fault read does not match inputs");

  a_therm_buck: assert property (
    CLK_EN && rd_fault && boost_mode_s |=> REG_RDATA[2:0] == 3'h0
  ) else $error("thermistor code shown outside buck mode");

  a_freeze_hold: assert property (
    !CLK_EN |=> $stable(st_ff)
  ) else $error("state moved while clock enable low");

  a_wdog_set: assert property (
    CLK_EN && WDOG_EXPIRE |=> st_ff.wdog_flt
  ) else $error("watchdog expiry did not set the fault flag");

  a_unmapped_read: assert property (
    CLK_EN && REG_RD && REG_ADDR != `ADDR_INPUT_CHARGE_STATUS &&
      REG_ADDR != `ADDR_FAULT_STATUS && REG_ADDR != `ADDR_INPUT_FLOOR_CTRL
      |=> REG_RDATA == 8'h00
  ) else $error("unmapped offset did not read zero");

  a_rdata_hold: assert property (
    CLK_EN && !REG_RD |=> $stable(REG_RDATA)
  ) else $error("read data moved without a read");

  a_charge_input: assert property (
    CLK_EN && rd_fault && (in_ovp_s || in_uv_s) |=>
      REG_RDATA[5:4] == 2'h1
  ) else $error("input fault not reported as charge fault");

  a_boost_cause: assert property (
    CLK_EN && rd_fault && boost_mode_s &&
      (boost_ovl_s || boost_ovp_s || boost_low_s) |=> REG_RDATA[6]
  ) else $error("boost fault cause not reported");

  a_therm_cold: assert property (
    CLK_EN && rd_fault && !boost_mode_s && ts_cold_s |=>
      REG_RDATA[2:0] == 3'h1
  ) else $error("cold thermistor not reported in buck mode");

endmodule : charger_status_fault_vin_floor_regs

/* hw/pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes the pins are independent levels; no multi-bit coherence
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_state_type;

  sync_state_type st_ff;
  sync_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.meta = async_in;
      nxt_st.held = st_ff.meta;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.held;

endmodule : pin_sync

/* tb/charger_status_fault_vin_floor_regs_tb.sv */
// self-checking bench for the charger status, fault and floor registers
// assumes the hw package, map header and host_bus_model compile first
`timescale 1ns/1ps

module charger_status_fault_vin_floor_regs_tb;
  import charger_regs_pkg::*;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic [18:0] pv      = 19'h0_0000;
  logic        wdog    = 1'b0;
  logic [6:0]  rel     = 7'h12;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic [7:0]  d2;
  logic        en      = 1'b1;
  logic        wr;
  logic        rd;
  logic        abs_sel;
  logic [6:0]  code;
  logic [13:0] mv;
  int          fails    = 0;
  int          compares = 0;
  int          cycles   = 0;
  // fault pin patterns and expected fault bytes; status pins kept low
  logic [18:0] fp [14] = '{19'h0_0180, 19'h0_0280, 19'h0_0480, 19'h0_0100,
    19'h0_0800, 19'h0_1000, 19'h0_2000, 19'h0_4000, 19'h0_2800,
    19'h0_8000, 19'h1_0000, 19'h2_0000, 19'h1_0080, 19'h3_0000};
  logic [7:0]  fe [14] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h10, 8'h10,
    8'h20, 8'h30, 8'h10, 8'h08, 8'h01, 8'h02, 8'h00, 8'h01};

  always #50 clk = ~clk;

  charger_status_fault_vin_floor_regs u_charger_status_fault_vin_floor_regs (
    .CLK                  (clk),
    .RESET_N              (reset_n),
    .CLK_EN               (en),
    .REG_ADDR             (addr),
    .REG_WR               (wr),
    .REG_WDATA            (wdata),
    .REG_RD               (rd),
    .REG_RDATA            (rdata),
    .SOURCE_TYPE_PIN      (pv[2:0]),
    .CHARGE_PHASE_PIN     (pv[4:3]),
    .POWER_GOOD_PIN       (pv[5]),
    .SYS_MIN_REG_PIN      (pv[6]),
    .BOOST_MODE_PIN       (pv[7]),
    .BOOST_OVERLOAD_PIN   (pv[8]),
    .BOOST_OVERVOLT_PIN   (pv[9]),
    .BOOST_BAT_LOW_PIN    (pv[10]),
    .INPUT_OVERVOLT_PIN   (pv[11]),
    .INPUT_UNDERVOLT_PIN  (pv[12]),
    .THERMAL_SHUTDOWN_PIN (pv[13]),
    .SAFETY_TIMER_PIN     (pv[14]),
    .BAT_OVERVOLT_PIN     (pv[15]),
    .TS_COLD_PIN          (pv[16]),
    .TS_HOT_PIN           (pv[17]),
    .VBUS_PRESENT_PIN     (pv[18]),
    .WDOG_EXPIRE          (wdog),
    .RELATIVE_FLOOR       (rel),
    .ABS_FLOOR_SELECT     (abs_sel),
    .INPUT_FLOOR_CODE     (code),
    .INPUT_FLOOR_MV       (mv)
  );

  host_bus_model u_host_bus_model (
    .clk       (clk),
    .reg_addr  (addr),
    .reg_wr    (wr),
    .reg_wdata (wdata),
    .reg_rd    (rd),
    .reg_rdata (rdata)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: mv got %h expected %h", $time, got, exp);
    end
  endtask : chk14

  // two sync edges plus margin before the pins are read back
  task automatic setp(input logic [18:0] v);
    @(posedge clk);
    pv <= v;
    repeat (3) @(posedge clk);
  endtask : setp

  task automatic tend(input string name);
    $display("test %s finished", name);
  endtask : tend

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    u_host_bus_model.rd_byte(8'h0d, d);
    chk8(d, 8'h12);
    u_host_bus_model.rd_byte(8'h20, d);
    chk8(d, 8'h00);
    tend("reset");
    for (int i = 0; i < 8; i++) begin
      setp({12'h000, i[1], i[0], i[1:0], i[2:0]});
      u_host_bus_model.rd_byte(8'h0b, d);
      chk8(d, {i[2:0], i[1:0], i[0], 1'b0, i[1]});
    end
    u_host_bus_model.wr_byte(8'h0b, 8'h00);
    u_host_bus_model.wr_byte(8'h0c, 8'hff);
    u_host_bus_model.rd_byte(8'h0b, d);
    chk8(d, 8'hfd);
    tend("status");
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk) wdog <= 1'b0;
    u_host_bus_model.rd_byte(8'h0c, d);
    chk8(d, 8'h80);
    u_host_bus_model.rd_byte(8'h0c, d);
    chk8(d, 8'h00);
    // expiry, then two reads on the next two edges
    @(posedge clk) wdog <= 1'b1;
    fork
      u_host_bus_model.rd_pair(8'h0c, d, d2);
      @(posedge clk) wdog <= 1'b0;
    join
    chk8(d, 8'h80);
    chk8(d2, 8'h00);
    for (int k = 0; k < 14; k++) begin
      setp(fp[k]);
      u_host_bus_model.rd_byte(8'h0c, d);
      chk8(d, fe[k]);
    end
    tend("fault");
    @(posedge clk) rel <= 7'h05;
    repeat (2) @(posedge clk);
    #1;
    chk8({abs_sel, code}, 8'h0d);
    chk14(mv, 14'h0f3c);
    u_host_bus_model.wr_byte(8'h0d, 8'h30);
    chk8({abs_sel, code}, 8'h0d);
    u_host_bus_model.wr_byte(8'h0d, 8'h80);
    chk8({abs_sel, code}, 8'h8d);
    u_host_bus_model.wr_byte(8'h0d, 8'hff);
    chk14(mv, 14'h3bc4);
    u_host_bus_model.rd_byte(8'h0d, d);
    chk8(d, 8'hff);
    u_host_bus_model.wr_byte(8'h0d, 8'h85);
    @(posedge clk) rel <= 7'h40;
    repeat (2) @(posedge clk);
    #1;
    chk8({abs_sel, code}, 8'h8d);
    // plug-in defaults last one cycle before relative tracking resumes
    @(posedge clk) pv <= 19'h4_0000;
    for (int k = 0; k < 8 && abs_sel !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk8({abs_sel, code}, 8'h12);
    chk14(mv, 14'h1130);
    u_host_bus_model.rd_byte(8'h0d, d);
    chk8(d, 8'h40);
    tend("floor");
    // clock enable low: a write and a read must both be ignored
    @(posedge clk) en <= 1'b0;
    u_host_bus_model.wr_byte(8'h0d, 8'h80);
    chk8({abs_sel, code}, 8'h40);
    u_host_bus_model.rd_byte(8'h0b, d);
    chk8(d, 8'h40);
    @(posedge clk) en <= 1'b1;
    tend("freeze");
    final_report();
  end
endmodule : charger_status_fault_vin_floor_regs_tb

/* tb/host_bus_model.sv */
// host model: single-byte reads and writes on the register port
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/1ps

module host_bus_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
    #1;
  endtask : wr_byte

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask : rd_byte

  // two reads on back-to-back edges; the strobe stays up between them
  task automatic rd_pair(input logic [7:0] a, output logic [7:0] v1,
                         output logic [7:0] v2);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    #1;
    v1 = reg_rdata;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v2 = reg_rdata;
  endtask : rd_pair
endmodule : host_bus_model
